// ### hw/dmm_byte_ram.sv
// Flip-flop byte store with one write port and one combinational read port
`timescale 1ns/1ps
module dmm_byte_ram
	import dmm_pkg::*;
#(
	parameter int unsigned DEPTH = 256
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Write port
	input wire logic wr_en,
	input wire logic [7:0] wr_addr,
	input wire logic [7:0] wr_data,
	// Read port
	input wire logic [7:0] rd_addr,
	output logic [7:0] rd_data
);

	logic [7:0] mem_reg [DEPTH];
	logic [7:0] mem_next [DEPTH];

	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			mem_next[i] = mem_reg[i];
		end
		if (wr_en) begin
			mem_next[wr_addr] = wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= DMM_RST_RAM_BYTE;
			end
		end else begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_reg[i] <= mem_next[i];
			end
		end
	end

	assign rd_data = mem_reg[rd_addr];

endmodule : dmm_byte_ram

// ### hw/dmm_decoder.sv
// Data memory map decoder: internal RAM, banks, special registers, expanded RAM
`timescale 1ns/1ps
module dmm_decoder
	import dmm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Core data access
	input wire logic req_valid,
	input wire dmm_req_s req,
	input wire logic pointer_sel,
	output logic rd_valid,
	output logic [7:0] rd_data,
	// Special registers held outside this block
	output logic sfr_ext_valid,
	output logic sfr_ext_write,
	output logic [7:0] sfr_ext_addr,
	output logic [7:0] sfr_ext_wdata,
	input wire logic [7:0] sfr_ext_rdata,
	// Program store decode
	input wire logic [15:0] prog_addr,
	output logic prog_addr_ok,
	// Register values for the core
	output logic [7:0] stack_pointer,
	output logic [7:0] program_status_word,
	output logic [15:0] pointer0,
	output logic [15:0] pointer1,
	output logic [7:0] expanded_data_ram_page_select
);

	// ==========================================================
	// Register state
	logic [7:0] stack_pointer_reg, stack_pointer_next;
	logic [7:0] pointer0_low_reg, pointer0_low_next;
	logic [7:0] pointer0_high_reg, pointer0_high_next;
	logic [7:0] pointer1_low_reg, pointer1_low_next;
	logic [7:0] pointer1_high_reg, pointer1_high_next;
	logic [7:0] expanded_data_ram_page_select_reg, expanded_data_ram_page_select_next;
	logic [7:0] program_status_word_reg, program_status_word_next;
	logic rd_valid_reg, rd_valid_next;
	logic [7:0] rd_data_reg, rd_data_next;

	// ==========================================================
	// Decode
	logic [1:0] active_bank;
	logic [7:0] internal_data_ram_addr;
	logic internal_data_ram_hit;
	logic sfr_hit;
	logic local_sfr;
	logic [7:0] local_sfr_rdata;
	logic [15:0] xdata_addr;
	logic expanded_data_ram_hit;
	logic expanded_data_ram_space;
	logic [7:0] internal_data_ram_rdata;
	logic [7:0] expanded_data_ram_rdata;
	logic internal_data_ram_we;
	logic expanded_data_ram_we;

	assign active_bank = {program_status_word_reg[DMM_BANK_SELECT_HIGH_BIT],
		program_status_word_reg[DMM_BANK_SELECT_LOW_BIT]};

	always_comb begin
		internal_data_ram_addr = req.addr[7:0];
		internal_data_ram_hit = 1'b0;
		sfr_hit = 1'b0;
		case (req.space)
			DMM_SP_DIRECT: begin
				if (req.addr[7:0] < 8'(DMM_LOW_RAM_BYTES)) begin
					internal_data_ram_hit = 1'b1;
				end else begin
					sfr_hit = 1'b1;
				end
			end
			DMM_SP_INDIRECT: begin
				internal_data_ram_hit = 1'b1;
			end
			DMM_SP_REGISTER: begin
				// Bank base is bank times eight, always inside 00H..1FH
				internal_data_ram_addr = {3'b000, active_bank, req.addr[2:0]};
				internal_data_ram_hit = 1'b1;
			end
			default: begin
				internal_data_ram_hit = 1'b0;
			end
		endcase
	end

	always_comb begin
		expanded_data_ram_space = 1'b0;
		xdata_addr = 16'h0000;
		case (req.space)
			DMM_SP_XDATA_PTR8: begin
				expanded_data_ram_space = 1'b1;
				xdata_addr = {expanded_data_ram_page_select_reg, req.addr[7:0]};
			end
			DMM_SP_XDATA_PTR16: begin
				expanded_data_ram_space = 1'b1;
				xdata_addr = pointer_sel ? {pointer1_high_reg, pointer1_low_reg} :
					{pointer0_high_reg, pointer0_low_reg};
			end
			default: begin
				expanded_data_ram_space = 1'b0;
			end
		endcase
	end

	// Only external moves reach this page; one page is the whole store
	assign expanded_data_ram_hit = expanded_data_ram_space && (xdata_addr[15:8] == DMM_EXPANDED_DATA_RAM_BASE_HIGH);

	always_comb begin
		local_sfr = 1'b1;
		local_sfr_rdata = 8'h00;
		case (req.addr[7:0])
			DMM_OFS_STACK_POINTER: local_sfr_rdata = stack_pointer_reg;
			DMM_OFS_POINTER0_LOW: local_sfr_rdata = pointer0_low_reg;
			DMM_OFS_POINTER0_HIGH: local_sfr_rdata = pointer0_high_reg;
			DMM_OFS_POINTER1_LOW: local_sfr_rdata = pointer1_low_reg;
			DMM_OFS_POINTER1_HIGH: local_sfr_rdata = pointer1_high_reg;
			DMM_OFS_EXPANDED_DATA_RAM_PAGE_SELECT: local_sfr_rdata = expanded_data_ram_page_select_reg;
			DMM_OFS_PROGRAM_STATUS_WORD: local_sfr_rdata = program_status_word_reg;
			default: local_sfr = 1'b0;
		endcase
	end

	assign internal_data_ram_we = req_valid && req.write && internal_data_ram_hit;
	// Misses are dropped so stray pointers cannot corrupt the page
	assign expanded_data_ram_we = req_valid && req.write && expanded_data_ram_hit;

	// ==========================================================
	// Stores
	dmm_byte_ram #(
		.DEPTH(DMM_INTERNAL_DATA_RAM_BYTES)
	) u_internal_data_ram (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(internal_data_ram_we),
		.wr_addr(internal_data_ram_addr),
		.wr_data(req.wdata),
		.rd_addr(internal_data_ram_addr),
		.rd_data(internal_data_ram_rdata)
	);

	dmm_byte_ram #(
		.DEPTH(DMM_EXPANDED_DATA_RAM_BYTES)
	) u_expanded_data_ram (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr_en(expanded_data_ram_we),
		.wr_addr(xdata_addr[7:0]),
		.wr_data(req.wdata),
		.rd_addr(xdata_addr[7:0]),
		.rd_data(expanded_data_ram_rdata)
	);

	// ==========================================================
	// Special registers outside this block get the access combinationally
	assign sfr_ext_valid = req_valid && sfr_hit && !local_sfr;
	assign sfr_ext_write = req.write;
	assign sfr_ext_addr = req.addr[7:0];
	assign sfr_ext_wdata = req.wdata;

	// ==========================================================
	// Program store lies in its own space, bounded to 8 kilobytes
	assign prog_addr_ok = (32'(prog_addr) < DMM_PROG_BYTES);

	// ==========================================================
	// Next state
	always_comb begin
		stack_pointer_next = stack_pointer_reg;
		pointer0_low_next = pointer0_low_reg;
		pointer0_high_next = pointer0_high_reg;
		pointer1_low_next = pointer1_low_reg;
		pointer1_high_next = pointer1_high_reg;
		expanded_data_ram_page_select_next = expanded_data_ram_page_select_reg;
		program_status_word_next = program_status_word_reg;
		rd_valid_next = 1'b0;
		rd_data_next = rd_data_reg;
		if (req_valid && req.write && sfr_hit && local_sfr) begin
			case (req.addr[7:0])
				DMM_OFS_STACK_POINTER: stack_pointer_next = req.wdata;
				DMM_OFS_POINTER0_LOW: pointer0_low_next = req.wdata;
				DMM_OFS_POINTER0_HIGH: pointer0_high_next = req.wdata;
				DMM_OFS_POINTER1_LOW: pointer1_low_next = req.wdata;
				DMM_OFS_POINTER1_HIGH: pointer1_high_next = req.wdata;
				DMM_OFS_EXPANDED_DATA_RAM_PAGE_SELECT: expanded_data_ram_page_select_next = req.wdata;
				DMM_OFS_PROGRAM_STATUS_WORD: program_status_word_next = req.wdata;
				default: stack_pointer_next = stack_pointer_reg;
			endcase
		end
		if (req_valid && !req.write) begin
			rd_valid_next = 1'b1;
			if (internal_data_ram_hit) begin
				rd_data_next = internal_data_ram_rdata;
			end else if (sfr_hit) begin
				rd_data_next = local_sfr ? local_sfr_rdata : sfr_ext_rdata;
			end else if (expanded_data_ram_hit) begin
				rd_data_next = expanded_data_ram_rdata;
			end else begin
				rd_data_next = DMM_EXPANDED_DATA_RAM_MISS_DATA;
			end
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			stack_pointer_reg <= DMM_RST_STACK_POINTER;
			pointer0_low_reg <= DMM_RST_POINTER;
			pointer0_high_reg <= DMM_RST_POINTER;
			pointer1_low_reg <= DMM_RST_POINTER;
			pointer1_high_reg <= DMM_RST_POINTER;
			expanded_data_ram_page_select_reg <= DMM_RST_EXPANDED_DATA_RAM_PAGE_SELECT;
			program_status_word_reg <= DMM_RST_PROGRAM_STATUS_WORD;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= 8'h00;
		end else begin
			stack_pointer_reg <= stack_pointer_next;
			pointer0_low_reg <= pointer0_low_next;
			pointer0_high_reg <= pointer0_high_next;
			pointer1_low_reg <= pointer1_low_next;
			pointer1_high_reg <= pointer1_high_next;
			expanded_data_ram_page_select_reg <= expanded_data_ram_page_select_next;
			program_status_word_reg <= program_status_word_next;
			rd_valid_reg <= rd_valid_next;
			rd_data_reg <= rd_data_next;
		end
	end

	// ==========================================================
	// Outputs
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign stack_pointer = stack_pointer_reg;
	assign program_status_word = program_status_word_reg;
	assign pointer0 = {pointer0_high_reg, pointer0_low_reg};
	assign pointer1 = {pointer1_high_reg, pointer1_low_reg};
	assign expanded_data_ram_page_select = expanded_data_ram_page_select_reg;

endmodule : dmm_decoder

// ### hw/dmm_pkg.sv
// Package of constants and types for the data memory map decoder
//
// Notes on behaviour
// - The bottom 128 internal RAM bytes answer both direct and indirect accesses.
// - Indirect accesses above 7FH land in upper internal RAM and never in the special registers.
// - Direct accesses above 7FH land in the special registers, which indirect accesses cannot reach.
// - Internal RAM bytes 00H to 1FH form four banks of eight working registers.
// - Status word bits 3 and 4 pick the active bank, and register accesses touch only that bank.
// - Expanded RAM sits at external addresses F000H to F0FFH and only external moves reach it.
// - An external move through an 8-bit pointer takes its high byte from the page register.
// - The page register resets to F0H, which selects the expanded RAM page F000H, and each page spans 256 bytes.
// - There are 256 bytes of internal RAM and 256 bytes of expanded RAM.
// - An 8 kilobyte program store exists apart from the data spaces.
package dmm_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned DMM_INTERNAL_DATA_RAM_BYTES = 256;
	localparam int unsigned DMM_EXPANDED_DATA_RAM_BYTES = 256;
	localparam int unsigned DMM_PROG_BYTES = 8192;
	localparam int unsigned DMM_LOW_RAM_BYTES = 128;
	localparam int unsigned DMM_BANK_REGS = 8;

	// ==========================================================
	// Special register offsets
	localparam logic [7:0] DMM_OFS_STACK_POINTER = 8'h81;
	localparam logic [7:0] DMM_OFS_POINTER0_LOW = 8'h82;
	localparam logic [7:0] DMM_OFS_POINTER0_HIGH = 8'h83;
	localparam logic [7:0] DMM_OFS_POINTER1_LOW = 8'h84;
	localparam logic [7:0] DMM_OFS_POINTER1_HIGH = 8'h85;
	localparam logic [7:0] DMM_OFS_EXPANDED_DATA_RAM_PAGE_SELECT = 8'h86;
	localparam logic [7:0] DMM_OFS_PROGRAM_STATUS_WORD = 8'hD0;

	// ==========================================================
	// Reset values
	localparam logic [7:0] DMM_RST_STACK_POINTER = 8'h07;
	localparam logic [7:0] DMM_RST_POINTER = 8'h00;
	localparam logic [7:0] DMM_RST_EXPANDED_DATA_RAM_PAGE_SELECT = 8'hF0;
	localparam logic [7:0] DMM_RST_PROGRAM_STATUS_WORD = 8'h00;
	localparam logic [7:0] DMM_RST_RAM_BYTE = 8'h00;

	// ==========================================================
	// Fields and fixed values
	localparam int unsigned DMM_BANK_SELECT_LOW_BIT = 3;
	localparam int unsigned DMM_BANK_SELECT_HIGH_BIT = 4;
	localparam logic [7:0] DMM_EXPANDED_DATA_RAM_BASE_HIGH = 8'hF0;
	localparam logic [7:0] DMM_EXPANDED_DATA_RAM_MISS_DATA = 8'hFF;

	// ==========================================================
	// Access kinds issued by the core
	typedef enum logic [2:0] {
		DMM_SP_DIRECT = 3'b000,
		DMM_SP_INDIRECT = 3'b001,
		DMM_SP_REGISTER = 3'b010,
		DMM_SP_XDATA_PTR8 = 3'b011,
		DMM_SP_XDATA_PTR16 = 3'b100
	} dmm_space_e;

	typedef struct packed {
		dmm_space_e space;
		logic write;
		logic [15:0] addr;
		logic [7:0] wdata;
	} dmm_req_s;

endpackage : dmm_pkg

// ### test/dmm_decoder_chk.sv
// Port assertions for the data memory map decoder
`timescale 1ns/1ps
module dmm_decoder_chk
	import dmm_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst,
	// Core access
	input wire logic req_valid,
	input wire dmm_req_s req,
	input wire logic rd_valid,
	input wire logic [7:0] rd_data,
	// Outside special registers
	input wire logic sfr_ext_valid,
	input wire logic sfr_ext_write,
	input wire logic [7:0] sfr_ext_addr,
	input wire logic [7:0] sfr_ext_wdata,
	input wire logic [7:0] sfr_ext_rdata,
	// Program store and registers
	input wire logic [15:0] prog_addr,
	input wire logic prog_addr_ok,
	input wire logic [7:0] stack_pointer,
	input wire logic [15:0] pointer0,
	input wire logic [15:0] pointer1,
	input wire logic [7:0] program_status_word,
	input wire logic [7:0] expanded_data_ram_page_select
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	logic rd_req, dir_w, up_ext;
	assign rd_req = req_valid && !req.write;
	assign dir_w = req_valid && req.write && req.space == DMM_SP_DIRECT;
	assign up_ext = req.space == DMM_SP_DIRECT && req.addr[7]
		&& !(req.addr[7:0] inside {[8'h81:8'h86], 8'hD0});
	// ====================
	// Checks
	read_pulse_a: assert property (rd_valid == $past(rd_req))
		else $error("read strobe off");
	ind_no_sfr_a: assert property (req_valid && req.space == DMM_SP_INDIRECT
		|-> !sfr_ext_valid)
		else $error("indirect hit special register");
	low_no_sfr_a: assert property (req_valid && !req.addr[7] |-> !sfr_ext_valid)
		else $error("low address hit special register");
	dir_sfr_a: assert property (req_valid && up_ext
		|-> sfr_ext_valid && sfr_ext_addr == req.addr[7:0])
		else $error("direct access not forwarded");
	fwd_fields_a: assert property (sfr_ext_valid
		|-> sfr_ext_write == req.write && sfr_ext_wdata == req.wdata)
		else $error("forwarded fields differ");
	sfr_data_a: assert property (rd_req && up_ext |=> rd_data == $past(sfr_ext_rdata))
		else $error("forwarded read data lost");
	page_hold_a: assert property (!(dir_w && req.addr[7:0] == 8'h86)
		|=> $stable(expanded_data_ram_page_select))
		else $error("page register moved");
	page_write_a: assert property (dir_w && req.addr[7:0] == 8'h86
		|=> expanded_data_ram_page_select == $past(req.wdata))
		else $error("page register not written");
	psw_write_a: assert property (dir_w && req.addr[7:0] == 8'hD0
		|=> program_status_word == $past(req.wdata))
		else $error("status word not written");
	sp_write_a: assert property (dir_w && req.addr[7:0] == 8'h81
		|=> stack_pointer == $past(req.wdata))
		else $error("stack pointer not written");
	ptr0_write_a: assert property (dir_w && req.addr[7:0] == 8'h83
		|=> pointer0[15:8] == $past(req.wdata))
		else $error("pointer0 high not written");
	ptr1_write_a: assert property (dir_w && req.addr[7:0] == 8'h84
		|=> pointer1[7:0] == $past(req.wdata))
		else $error("pointer1 low not written");
	miss_read_a: assert property (rd_req && req.space == DMM_SP_XDATA_PTR8
		&& expanded_data_ram_page_select != 8'hF0 |=> rd_data == 8'hFF)
		else $error("page miss read not fixed");
	prog_range_a: assert property (prog_addr_ok == (prog_addr < 16'h2000))
		else $error("program range wrong");
endmodule : dmm_decoder_chk

bind dmm_decoder dmm_decoder_chk dmm_decoder_chk_i (.clk_sys, .rst, .req_valid, .req, .rd_valid,
	.rd_data, .sfr_ext_valid, .sfr_ext_write, .sfr_ext_addr, .sfr_ext_wdata, .sfr_ext_rdata,
	.prog_addr, .prog_addr_ok, .stack_pointer, .pointer0, .pointer1,
	.program_status_word, .expanded_data_ram_page_select);

// ### test/dmm_sfr_model.sv
// Model of the peripheral special registers beyond the decoder
`timescale 1ns/1ps
module dmm_sfr_model (
	// Clock
	input wire logic clk_sys,
	// Access from the decoder
	input wire logic sfr_ext_valid,
	input wire logic [7:0] sfr_ext_addr,
	output logic [7:0] sfr_ext_rdata
);
	logic [7:0] churn_reg = 8'h00;
	// ====================
	// Unselected value churns so a stale capture cannot pass
	always_ff @(posedge clk_sys)
		churn_reg <= churn_reg + 8'h3B;
	assign sfr_ext_rdata = sfr_ext_valid ? {sfr_ext_addr[3:0], sfr_ext_addr[7:4]} : churn_reg;
endmodule : dmm_sfr_model

// ### test/testbench.sv
// Self-checking bench for the data memory map decoder
`timescale 1ns/1ps
module testbench
	import dmm_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic req_valid = 1'b0;
	dmm_req_s req = '0;
	logic pointer_sel = 1'b0;
	logic [15:0] prog_addr = 16'h0000;
	logic rd_valid, sfr_ext_valid, sfr_ext_write, prog_addr_ok;
	logic [7:0] rd_data, sfr_ext_addr, sfr_ext_wdata, sfr_ext_rdata;
	logic [7:0] stack_pointer, program_status_word, expanded_data_ram_page_select;
	logic [15:0] pointer0, pointer1;
	logic [7:0] internal_data_ram [256];
	logic [7:0] expanded_data_ram [256];
	logic [7:0] regs [8];
	logic [7:0] psw_m;
	logic [7:0] exp_q [$];
	logic [7:0] ofs [7] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'hD0};
	int bad_count = 0;
	int comparisons = 0;
	integer seed = 32'h3B222224;

	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		prog_addr <= 16'($random(seed));

	dmm_decoder dmm_decoder_i (.clk_sys(clk_sys), .rst(rst), .req_valid(req_valid), .req(req),
		.pointer_sel(pointer_sel), .rd_valid(rd_valid), .rd_data(rd_data),
		.sfr_ext_valid(sfr_ext_valid), .sfr_ext_write(sfr_ext_write), .sfr_ext_addr(sfr_ext_addr),
		.sfr_ext_wdata(sfr_ext_wdata), .sfr_ext_rdata(sfr_ext_rdata), .prog_addr(prog_addr),
		.prog_addr_ok(prog_addr_ok), .stack_pointer(stack_pointer),
		.program_status_word(program_status_word), .pointer0(pointer0), .pointer1(pointer1),
		.expanded_data_ram_page_select(expanded_data_ram_page_select));
	dmm_sfr_model dmm_sfr_model_i (.clk_sys(clk_sys), .sfr_ext_valid(sfr_ext_valid),
		.sfr_ext_addr(sfr_ext_addr), .sfr_ext_rdata(sfr_ext_rdata));

	// ====================
	// Reference model and driver
	function automatic dmm_req_s mk(dmm_space_e s, logic w, logic [7:0] a, logic [7:0] d);
		return '{s, w, {8'h00, a}, d};
	endfunction : mk

	task automatic model_reset();
		internal_data_ram = '{default: 8'h00};
		expanded_data_ram = '{default: 8'h00};
		regs = '{8'h00, 8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0, 8'h00};
		psw_m = 8'h00;
	endtask : model_reset

	task automatic issue(input dmm_req_s r, input logic psel);
		logic [15:0] xa;
		logic [7:0] ia;
		logic [7:0] v;
		xa = psel ? {regs[5], regs[4]} : {regs[3], regs[2]};
		if (r.space == DMM_SP_XDATA_PTR8)
			xa = {regs[6], r.addr[7:0]};
		ia = (r.space == DMM_SP_REGISTER) ? {3'h0, psw_m[4:3], r.addr[2:0]} : r.addr[7:0];
		if (r.space == DMM_SP_DIRECT && ia[7]) begin
			v = (ia == 8'hD0) ? psw_m : {ia[3:0], ia[7:4]};
			if (ia inside {[8'h81:8'h86]})
				v = regs[ia[2:0]];
			if (r.write && ia == 8'hD0)
				psw_m = r.wdata;
			else if (r.write && ia inside {[8'h81:8'h86]})
				regs[ia[2:0]] = r.wdata;
		end else if (r.space inside {DMM_SP_XDATA_PTR8, DMM_SP_XDATA_PTR16}) begin
			v = (xa[15:8] == 8'hF0) ? expanded_data_ram[xa[7:0]] : 8'hFF;
			if (r.write && xa[15:8] == 8'hF0)
				expanded_data_ram[xa[7:0]] = r.wdata;
		end else begin
			v = internal_data_ram[ia];
			if (r.write)
				internal_data_ram[ia] = r.wdata;
		end
		if (!r.write)
			exp_q.push_back(v);
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req <= r;
		pointer_sel <= psel;
	endtask : issue

	task automatic rand_op();
		dmm_req_s r;
		logic [31:0] x;
		x = $random(seed);
		r = '{dmm_space_e'(3'(x[2:0] % 3'd5)), x[3], x[31:16], (x[3] && x[4]) ? 8'hF0 : x[15:8]};
		if (x[5])
			r.addr[7:0] = x[6] ? 8'hD0 : {5'h10, x[18:16]};
		if (x[27:25] == 3'h0) begin
			@(posedge clk_sys);
			req_valid <= 1'b0;
			req <= r;
		end else
			issue(r, x[7]);
	endtask : rand_op

	task automatic drain();
		int n;
		n = 0;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		while (exp_q.size() != 0 && n < 8) begin
			@(posedge clk_sys);
			n++;
		end
		if (exp_q.size() != 0) begin
			bad_count++;
			$display("unexpected hang at %0t: %0h reads unanswered", $time, exp_q.size());
			conclude();
		end
	endtask : drain

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : conclude

	// ====================
	// Read result checker
	always @(posedge clk_sys) begin
		logic [7:0] e;
		if (!rst && rd_valid === 1'b1) begin
			e = (exp_q.size() != 0) ? exp_q.pop_front() : 8'hXX;
			comparisons++;
			if (rd_data !== e) begin
				bad_count++;
				$display("unexpected read at %0t: got %h expected %h", $time, rd_data, e);
			end
		end
	end

	// ====================
	// Sequence
	initial begin
		for (int k = 0; k < 2; k++) begin
			rst <= 1'b1;
			model_reset();
			repeat (16) @(posedge clk_sys);
			rst <= 1'b0;
			foreach (ofs[i])
				issue(mk(DMM_SP_DIRECT, 1'b0, ofs[i], 8'h00), 1'b0);
			for (int b = 0; b < 4; b++) begin
				issue(mk(DMM_SP_DIRECT, 1'b1, 8'hD0, 8'(b << 3)), 1'b0);
				issue(mk(DMM_SP_REGISTER, 1'b1, 8'(b), 8'(8'hA0 + b)), 1'b0);
				issue(mk(DMM_SP_REGISTER, 1'b0, 8'(b), 8'h00), 1'b0);
			end
			for (int b = 0; b < 32; b += 9)
				issue(mk(DMM_SP_INDIRECT, 1'b0, 8'(b), 8'h00), 1'b0);
			issue(mk(DMM_SP_INDIRECT, 1'b1, 8'h90, 8'hA5), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b0, 8'h90, 8'h00), 1'b0);
			issue(mk(DMM_SP_INDIRECT, 1'b0, 8'h90, 8'h00), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b1, 8'h7F, 8'h5A), 1'b0);
			issue(mk(DMM_SP_INDIRECT, 1'b0, 8'h7F, 8'h00), 1'b0);
			issue(mk(DMM_SP_XDATA_PTR8, 1'b1, 8'hFF, 8'h3C), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b1, 8'h86, 8'hF1), 1'b0);
			issue(mk(DMM_SP_XDATA_PTR8, 1'b1, 8'hFF, 8'h77), 1'b0);
			issue(mk(DMM_SP_XDATA_PTR8, 1'b0, 8'hFF, 8'h00), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b1, 8'h86, 8'hF0), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b1, 8'h85, 8'hF0), 1'b0);
			issue(mk(DMM_SP_DIRECT, 1'b1, 8'h84, 8'hFF), 1'b0);
			issue(mk(DMM_SP_XDATA_PTR16, 1'b0, 8'h00, 8'h00), 1'b1);
			issue(mk(DMM_SP_XDATA_PTR16, 1'b0, 8'h00, 8'h00), 1'b0);
			repeat (400) rand_op();
			drain();
		end
		conclude();
	end
endmodule : testbench
